// file: testbench/alu_chk.sv
// Watches the accumulator slice at its ports and checks timing of results and skips.
module alu_chk (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic op_valid_in,
    input wire logic [3:0] op_code_in,
    input wire logic [5:0] file_addr_in,
    input wire logic dest_sel_in,
    input wire logic [7:0] immediate_in,
    input wire logic skip_cond_in,
    input wire logic op_ready_out,
    input wire logic [7:0] accumulator_out,
    input wire logic carry_flag_out,
    input wire logic digit_carry_flag_out,
    input wire logic zero_flag_out,
    input wire logic file_wr_out,
    input wire logic [5:0] file_wr_addr_out,
    input wire logic [7:0] file_wr_data_out,
    input wire logic skip_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // An instruction counts only when it is presented while the slice is ready.
    wire logic tk = op_valid_in && op_ready_out;
    // Register forms are the only ones that honour the destination select.
    wire logic rf = tk && (op_code_in inside {4'h1, 4'h2, 4'h4});
    AST_SKIP_TAKEN: assert property (tk && op_code_in == 4'h6 && skip_cond_in |=>
        !op_ready_out && skip_busy_out ##1 op_ready_out && !skip_busy_out)
        else $error("taken skip did not span exactly two cycles");
    AST_SKIP_NOT: assert property (tk && op_code_in == 4'h6 && !skip_cond_in |=>
        op_ready_out && !skip_busy_out) else $error("untaken skip stalled");
    AST_SKIP_HOLD: assert property (skip_busy_out |=>
        $stable(accumulator_out) && !file_wr_out) else $error("skipped slot changed data");
    AST_DEST_ACC: assert property (rf && !dest_sel_in |=> !file_wr_out)
        else $error("file written with accumulator destination");
    AST_DEST_FILE: assert property (rf && dest_sel_in |=> file_wr_out &&
        file_wr_addr_out == $past(file_addr_in) && $stable(accumulator_out))
        else $error("file destination not written next cycle");
    AST_IMM_ADD: assert property (tk && op_code_in == 4'h3 |=> !file_wr_out &&
        {carry_flag_out, accumulator_out} == $past(accumulator_out) + $past(immediate_in))
        else $error("immediate add result wrong");
    AST_AND_FLAGS: assert property (tk && (op_code_in inside {4'h4, 4'h5}) |=>
        $stable(carry_flag_out) && $stable(digit_carry_flag_out))
        else $error("logical op changed carry flags");
    AST_ZERO_WR: assert property (file_wr_out |->
        zero_flag_out == (file_wr_data_out == 8'h00)) else $error("zero flag wrong");
endmodule // alu_chk

bind accumulator_alu alu_chk chk (.clk_in(clk_in), .resetn_in(resetn_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in), .file_addr_in(file_addr_in),
    .dest_sel_in(dest_sel_in), .immediate_in(immediate_in), .skip_cond_in(skip_cond_in),
    .op_ready_out(op_ready_out), .accumulator_out(accumulator_out),
    .carry_flag_out(carry_flag_out), .digit_carry_flag_out(digit_carry_flag_out),
    .zero_flag_out(zero_flag_out), .file_wr_out(file_wr_out),
    .file_wr_addr_out(file_wr_addr_out), .file_wr_data_out(file_wr_data_out),
    .skip_busy_out(skip_busy_out));

// file: testbench/test_accumulator_alu.sv
module test_accumulator_alu;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
        $display("unexpected at %0t got %h expected %h", $time, g, e); end end
    logic clk_in = 1'b0, resetn_in = 1'b0, op_valid_in = 1'b0, dest_sel_in = 1'b0;
    logic skip_cond_in = 1'b0;
    logic [3:0] op_code_in = 4'h0;
    logic [5:0] file_addr_in = 6'h00, next_file_addr_in = 6'h00, file_wr_addr_out;
    logic [7:0] immediate_in = 8'h00, accumulator_out, file_wr_data_out;
    logic op_ready_out, carry_flag_out, digit_carry_flag_out, zero_flag_out;
    logic file_wr_out, skip_busy_out;
    int n_mismatch = 0, compares = 0;
    // Reference copy of the architectural state.
    logic [7:0] m_accum = 8'h00, m_file [64];
    logic m_c = 1'b0, m_hc = 1'b0, m_z = 1'b0;

    accumulator_alu uut (.clk_in(clk_in), .resetn_in(resetn_in), .op_valid_in(op_valid_in),
        .op_code_in(op_code_in), .file_addr_in(file_addr_in),
        .next_file_addr_in(next_file_addr_in), .dest_sel_in(dest_sel_in),
        .immediate_in(immediate_in), .skip_cond_in(skip_cond_in), .op_ready_out(op_ready_out),
        .accumulator_out(accumulator_out), .carry_flag_out(carry_flag_out),
        .digit_carry_flag_out(digit_carry_flag_out), .zero_flag_out(zero_flag_out),
        .file_wr_out(file_wr_out), .file_wr_addr_out(file_wr_addr_out),
        .file_wr_data_out(file_wr_data_out), .skip_busy_out(skip_busy_out));

    // Free-running 100 MHz clock.
    initial begin
        forever #5 clk_in = ~clk_in;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Updates the reference, issues one instruction after an idle cycle and checks it.
    task automatic run_op(input logic [3:0] op, input logic [5:0] a, input logic d,
                          input logic [7:0] imm);
        logic [7:0] b, res;
        logic [8:0] s;
        logic [4:0] h;
        logic cin, wr;
        b = (op == 4'h3 || op == 4'h5) ? imm : m_file[a];
        cin = (op == 4'h1) ? m_c : 1'b0;
        s = {1'b0, m_accum} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, m_accum[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        wr = d && (op inside {4'h1, 4'h2, 4'h4});
        res = (op == 4'h4 || op == 4'h5) ? (m_accum & b) : s[7:0];
        if (!(op == 4'h4 || op == 4'h5)) begin
            m_c = s[8];
            m_hc = h[4];
        end
        m_z = (res == 8'h00);
        if (wr) m_file[a] = res;
        else m_accum = res;
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        next_file_addr_in <= a;
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_code_in <= op;
        file_addr_in <= a;
        dest_sel_in <= d;
        immediate_in <= imm;
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        #1;
        `CHK(accumulator_out, m_accum)
        `CHK(carry_flag_out, m_c)
        `CHK(({digit_carry_flag_out, zero_flag_out}), ({m_hc, m_z}))
        `CHK(file_wr_out, wr)
        if (wr) `CHK(({file_wr_addr_out, file_wr_data_out}), ({a, res}))
    endtask

    // Logical forms: clears the file locations used later, at both address ends.
    task automatic t_logic;
        run_op(4'h5, 6'h00, 1'b0, 8'h00);
        run_op(4'h4, 6'h00, 1'b1, 8'h00);
        run_op(4'h4, 6'h3f, 1'b1, 8'h00);
        $display("logic test done");
    endtask

    // Additions with boundary immediates, carries and both destinations.
    task automatic t_add;
        run_op(4'h3, 6'h00, 1'b0, 8'hff);
        run_op(4'h3, 6'h00, 1'b0, 8'h01);
        run_op(4'h3, 6'h15, 1'b1, 8'h3a);
        run_op(4'h2, 6'h3f, 1'b1, 8'h00);
        run_op(4'h2, 6'h3f, 1'b0, 8'h00);
        run_op(4'h3, 6'h00, 1'b0, 8'hc8);
        run_op(4'h1, 6'h00, 1'b0, 8'h00);
        run_op(4'h1, 6'h3f, 1'b1, 8'h00);
        run_op(4'h4, 6'h3f, 1'b0, 8'h00);
        $display("add test done");
    endtask

    // Skip op, then an accumulator-clearing op in the slot that a taken skip swallows.
    task automatic t_skip(input logic cond);
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_code_in <= 4'h6;
        skip_cond_in <= cond;
        @(posedge clk_in);
        op_code_in <= 4'h5;
        immediate_in <= 8'h00;
        #1;
        `CHK(({skip_busy_out, op_ready_out}), ({cond, !cond}))
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        #1;
        if (!cond) begin
            m_accum = 8'h00;
            m_z = 1'b1;
        end
        `CHK(({accumulator_out, zero_flag_out, op_ready_out}), ({m_accum, m_z, 1'b1}))
        $display("skip test done");
    endtask

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_logic();
        t_add();
        t_skip(1'b1);
        t_skip(1'b0);
        complete_run();
    end

    // Cuts a hang short.
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
endmodule // test_accumulator_alu

// file: verilog/accumulator_alu.sv
// Operation
// - Taken skip lasts two cycles, else one
// - File operand is six-bit address 00h-3Fh
// - Destination bit zero accumulator, one file
// - Add-with-carry sums file, accumulator, carry
// - Add-with-carry updates carry, digit carry, zero
// - Plain add, no carry-in, updates three flags
// - Add immediate always writes the accumulator
// - Immediate accepts any value 0 to 255
// - AND register writes selected destination, immediate the accumulator, zero flag only
`include "alu_regs.svh"

// Accumulator datapath slice. An instruction is presented with op_valid_in for
// one cycle; the file register is read through a lookahead address so that its
// data is ready in the executing cycle, and the result is committed at the
// end of that same cycle. Instructions are presented back to back.
module accumulator_alu #(
    parameter int DATA_W = `DATA_W,
    parameter int ADDR_W = `ADDR_W
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic op_valid_in,
    input wire logic [3:0] op_code_in,
    input wire logic [ADDR_W-1:0] file_addr_in,
    input wire logic [ADDR_W-1:0] next_file_addr_in,
    input wire logic dest_sel_in,
    input wire logic [DATA_W-1:0] immediate_in,
    input wire logic skip_cond_in,
    output logic op_ready_out,
    output logic [DATA_W-1:0] accumulator_out,
    output logic carry_flag_out,
    output logic digit_carry_flag_out,
    output logic zero_flag_out,
    output logic file_wr_out,
    output logic [ADDR_W-1:0] file_wr_addr_out,
    output logic [DATA_W-1:0] file_wr_data_out,
    output logic skip_busy_out
);

    // The digit carry needs a low nibble and the address must fit the map.
    if (DATA_W != `DATA_W || ADDR_W != `ADDR_W) begin : g_bad
        $error("accumulator_alu: only an 8-bit path and 6-bit address are served.");
    end

    // Decoded operation.
    alu_pkg::alu_op_t op;
    // Registered read word of the addressed file register.
    logic [DATA_W-1:0] file_data;
    // Accumulator and flag state with next values.
    logic [DATA_W-1:0] accumulator_r, accumulator_nxt;
    logic carry_r, carry_nxt;
    logic digit_carry_r, digit_carry_nxt;
    logic zero_r, zero_nxt;
    // Registered file write port.
    logic wr_r, wr_nxt;
    logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
    logic [DATA_W-1:0] wr_data_r, wr_data_nxt;
    // Cycle state.
    alu_pkg::cycle_state_t state_r, state_nxt;
    // Operation result and helpers.
    logic [DATA_W-1:0] opnd_b;
    logic [DATA_W:0] sum;
    logic [4:0] low_sum;
    logic carry_in;
    logic [DATA_W-1:0] result;
    logic is_add;
    logic is_and;
    logic writes_file;
    // Bypass so that a file write is visible to the very next instruction.
    logic [ADDR_W-1:0] last_rd_addr_r;
    logic [DATA_W-1:0] file_operand;

    // File register memory; its read address is the next instruction's operand.
    file_ram #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_file_ram (
        .clk_in(clk_in),
        .rd_addr_in(next_file_addr_in),
        .rd_data_out(file_data),
        .wr_en_in(wr_nxt),
        .wr_addr_in(wr_addr_nxt),
        .wr_data_in(wr_data_nxt)
    );

    // Remember which address was read, for the bypass compare.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            last_rd_addr_r <= `FILE_ADDR_MIN;
        end else begin
            last_rd_addr_r <= next_file_addr_in;
        end
    end

    // A read and a write of one word on the same edge leave the read word stale,
    // so the word written at that edge is forwarded in its place.
    always_comb begin
        if (wr_r && wr_addr_r == last_rd_addr_r) begin
            file_operand = wr_data_r;
        end else begin
            file_operand = file_data;
        end
    end

    // Decode and compute the result of the current operation.
    always_comb begin
        op = alu_pkg::alu_op_t'(op_code_in);
        is_add = 1'b0;
        is_and = 1'b0;
        carry_in = 1'b0;
        writes_file = 1'b0;
        opnd_b = file_operand;
        case (op)
            alu_pkg::add_reg_with_carry_op: begin
                is_add = 1'b1;
                carry_in = carry_r;
                writes_file = dest_sel_in == `DEST_FILE;
            end
            alu_pkg::add_reg_op: begin
                is_add = 1'b1;
                writes_file = dest_sel_in == `DEST_FILE;
            end
            alu_pkg::add_immediate_op: begin
                is_add = 1'b1;
                opnd_b = immediate_in;
            end
            alu_pkg::and_reg_op: begin
                is_and = 1'b1;
                writes_file = dest_sel_in == `DEST_FILE;
            end
            alu_pkg::and_immediate_op: begin
                is_and = 1'b1;
                opnd_b = immediate_in;
            end
            default: begin
            end
        endcase
        sum = {1'b0, accumulator_r} + {1'b0, opnd_b} + {{DATA_W{1'b0}}, carry_in};
        low_sum = {1'b0, accumulator_r[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, carry_in};
        if (is_and) begin
            result = accumulator_r & opnd_b;
        end else begin
            result = sum[DATA_W-1:0];
        end
    end

    // Next state of accumulator, flags, write port and skip sequencing.
    always_comb begin
        accumulator_nxt = accumulator_r;
        carry_nxt = carry_r;
        digit_carry_nxt = digit_carry_r;
        zero_nxt = zero_r;
        wr_nxt = 1'b0;
        wr_addr_nxt = file_addr_in;
        wr_data_nxt = result;
        state_nxt = state_r;
        case (state_r)
            alu_pkg::st_run: begin
                if (op_valid_in && op == alu_pkg::skip_test_op) begin
                    if (skip_cond_in) begin
                        state_nxt = alu_pkg::st_skip;
                    end
                end else if (op_valid_in && (is_add || is_and)) begin
                    // Whole operation commits at this edge.
                    if (writes_file) begin
                        wr_nxt = 1'b1;
                    end else begin
                        accumulator_nxt = result;
                    end
                    zero_nxt = result == {DATA_W{1'b0}};
                    if (is_add) begin
                        carry_nxt = sum[DATA_W];
                        digit_carry_nxt = low_sum[`DIGIT_CARRY_BIT];
                    end
                end
            end
            alu_pkg::st_skip: begin
                // Second cycle of a taken skip; the skipped word is discarded.
                state_nxt = alu_pkg::st_run;
            end
            default: begin
                state_nxt = alu_pkg::st_run;
            end
        endcase
    end

    // Register all datapath state.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            accumulator_r <= `ACCUMULATOR_RESET;
            carry_r <= `FLAG_RESET;
            digit_carry_r <= `FLAG_RESET;
            zero_r <= `FLAG_RESET;
            wr_r <= 1'b0;
            wr_addr_r <= `FILE_ADDR_MIN;
            wr_data_r <= `ACCUMULATOR_RESET;
            state_r <= alu_pkg::st_run;
        end else begin
            accumulator_r <= accumulator_nxt;
            carry_r <= carry_nxt;
            digit_carry_r <= digit_carry_nxt;
            zero_r <= zero_nxt;
            wr_r <= wr_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
            state_r <= state_nxt;
        end
    end

    // Outputs.
    assign op_ready_out = state_r == alu_pkg::st_run;
    assign skip_busy_out = state_r == alu_pkg::st_skip;
    assign accumulator_out = accumulator_r;
    assign carry_flag_out = carry_r;
    assign digit_carry_flag_out = digit_carry_r;
    assign zero_flag_out = zero_r;
    assign file_wr_out = wr_r;
    assign file_wr_addr_out = wr_addr_r;
    assign file_wr_data_out = wr_data_r;

endmodule // accumulator_alu

// file: verilog/alu_pkg.sv
package alu_pkg;

    // Operation selected for the current instruction cycle.
    typedef enum logic [3:0] {
        op_none_t_code = 4'h0,
        add_reg_with_carry_op = 4'h1,
        add_reg_op = 4'h2,
        add_immediate_op = 4'h3,
        and_reg_op = 4'h4,
        and_immediate_op = 4'h5,
        skip_test_op = 4'h6
    } alu_op_t;

    // Cycle state: one-hot, the second state covers a taken skip.
    typedef enum logic [1:0] {
        st_run = 2'b01,
        st_skip = 2'b10
    } cycle_state_t;

endpackage

// file: verilog/alu_regs.svh
`ifndef ALU_REGS_SVH
`define ALU_REGS_SVH

// Width of the data path.
`define DATA_W 8
// Width of the file-register address field.
`define ADDR_W 6
// Lowest and highest file-register address.
`define FILE_ADDR_MIN 6'h00
`define FILE_ADDR_MAX 6'h3f
// Number of file-register locations.
`define FILE_DEPTH 64
// Destination select values.
`define DEST_ACCUMULATOR 1'b0
`define DEST_FILE 1'b1
// Cycles taken by a skip instruction.
`define SKIP_TAKEN_CYCLES 2
`define SKIP_NOT_TAKEN_CYCLES 1
// Reset values of accumulator and flags.
`define ACCUMULATOR_RESET 8'h00
`define FLAG_RESET 1'b0
// Bit position of the half-byte carry.
`define DIGIT_CARRY_BIT 4

`endif

// file: verilog/file_ram.sv
`include "alu_regs.svh"

// Small file-register memory with registered read data and one write port.
module file_ram #(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W
) (
    input wire logic clk_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [DATA_W-1:0] rd_data_out,
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [DATA_W-1:0] wr_data_in
);

    // Storage array; contents are not reset, as in real file memory.
    logic [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];

    // Elaboration-time check of the shape.
    if (ADDR_W < 1 || DATA_W < 1) begin : g_bad
        $error("file_ram: widths must be positive.");
    end

    // Write when asked and register the read word.
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_r[rd_addr_in];
    end

endmodule // file_ram
